// file: rtl/fsc_link_if.sv
// Link between the fieldbus master end and the slave end.
`timescale 1ns/1ps
interface fsc_link_if;
  import fsc_pkg::*;

  fsc_op_t op; // Transaction kind.
  logic valid; // Request held until ack.
  logic [15:0] index; // Object index or register number.
  logic [7:0] sub; // Object subindex.
  logic [15:0] wdata; // Write data or target state.
  logic ack; // One-cycle answer strobe.
  logic err; // Request refused, valid with ack.
  logic [15:0] rdata; // Read data, valid with ack.
  fsc_state_t state; // Current slave state.
  logic rpdo_valid; // Cyclic output data valid.
  logic [31:0] rpdo_data; // Cyclic data master to slave.
  logic tpdo_valid; // Cyclic input data valid.
  logic [31:0] tpdo_data; // Cyclic data slave to master.

  // Slave end.
  modport dev (
    input op, valid, index, sub, wdata, rpdo_valid, rpdo_data,
    output ack, err, rdata, state, tpdo_valid, tpdo_data
  );

  // Master end.
  modport mst (
    output op, valid, index, sub, wdata, rpdo_valid, rpdo_data,
    input ack, err, rdata, state, tpdo_valid, tpdo_data
  );
endinterface

// file: rtl/fsc_master.sv
// Fieldbus master end driven by software over APB.
`timescale 1ns/1ps
module fsc_master (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  fsc_link_if.mst lnk // Link to the slave.
);
  import fsc_pkg::*;

  logic valid_q; // Request outstanding.
  fsc_op_t op_q; // Request kind.
  logic [15:0] index_q; // Request index.
  logic [7:0] sub_q; // Request subindex.
  logic [15:0] wdata_q; // Request write data.
  logic [15:0] rdata_q; // Last read answer.
  logic err_q; // Last request refused.
  logic cyc_en_q; // Cyclic output enable.
  logic [31:0] rpdo_q; // Cyclic output data.
  logic [31:0] tpdo_q; // Last cyclic input data.
  logic [31:0] prdata_q; // Read data captured at setup.
  logic wr_en; // APB write takes effect.
  logic mapped; // Address decodes to a register.

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= APB_TPDO;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  assign lnk.op = op_q;
  assign lnk.valid = valid_q;
  assign lnk.index = index_q;
  assign lnk.sub = sub_q;
  assign lnk.wdata = wdata_q;
  assign lnk.rpdo_valid = cyc_en_q;
  assign lnk.rpdo_data = rpdo_q;

  // Read data is prepared in the setup cycle for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        APB_ADDR: prdata_q <= {8'h00, sub_q, index_q};
        APB_WDATA: prdata_q <= {16'h0000, wdata_q};
        APB_RDATA: prdata_q <= {16'h0000, rdata_q};
        APB_STATUS: prdata_q <= {26'h0, lnk.state, 2'b00, err_q, valid_q};
        APB_CYC: prdata_q <= {31'h0, cyc_en_q};
        APB_RPDO: prdata_q <= rpdo_q;
        APB_TPDO: prdata_q <= tpdo_q;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Software registers for address, data and cyclic control.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_q <= 16'h0000;
      sub_q <= 8'h00;
      wdata_q <= 16'h0000;
      cyc_en_q <= 1'b0;
      rpdo_q <= 32'h0000_0000;
    end else if (wr_en && !valid_q) begin
      // Request fields are frozen while a request is outstanding.
      case (paddr)
        APB_ADDR: begin
          index_q <= pwdata[15:0];
          sub_q <= pwdata[23:16];
        end
        APB_WDATA: wdata_q <= pwdata[15:0];
        APB_CYC: cyc_en_q <= pwdata[0];
        APB_RPDO: rpdo_q <= pwdata;
        default: begin
        end
      endcase
    end else if (wr_en && paddr == APB_RPDO) begin
      rpdo_q <= pwdata;
    end
  end

  // Command issue and answer capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
      op_q <= FSC_OP_NONE;
      rdata_q <= 16'h0000;
      err_q <= 1'b0;
    end else if (valid_q && lnk.ack) begin
      valid_q <= 1'b0;
      rdata_q <= lnk.rdata;
      err_q <= lnk.err;
    end else if (wr_en && paddr == APB_CMD && !valid_q) begin
      if (fsc_op_t'(pwdata[2:0]) == FSC_OP_STATE_REQ &&
          wdata_q[1:0] == FSC_ST_OP && !cyc_en_q) begin
        err_q <= 1'b1;
      end else if (pwdata[2:0] != 3'b000 && pwdata[2:0] <= 3'b101) begin
        // Register writes configure address, mailbox and clock.
        // Mailbox writes set up the process data mapping.
        op_q <= fsc_op_t'(pwdata[2:0]);
        valid_q <= 1'b1;
        err_q <= 1'b0;
      end
    end
  end

  // Cyclic input data is captured whenever the slave sends it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tpdo_q <= 32'h0000_0000;
    end else if (lnk.tpdo_valid) begin
      tpdo_q <= lnk.tpdo_data;
    end
  end
endmodule

// file: rtl/fsc_pkg.sv
// Shared constants and types for the fieldbus slave state control block.
package fsc_pkg;

  // Communication states of the slave, lowest to highest.
  typedef enum logic [1:0] {
    FSC_ST_INIT,
    FSC_ST_PREOP,
    FSC_ST_SAFEOP,
    FSC_ST_OP
  } fsc_state_t;

  // Transaction kinds carried on the acyclic link channel.
  typedef enum logic [2:0] {
    FSC_OP_NONE,
    FSC_OP_REG_WR,
    FSC_OP_REG_RD,
    FSC_OP_MBX_WR,
    FSC_OP_MBX_RD,
    FSC_OP_STATE_REQ
  } fsc_op_t;

  // Object index classes.
  typedef enum logic [1:0] {
    FSC_CL_RSVD,
    FSC_CL_COMM,
    FSC_CL_MANUF,
    FSC_CL_PROF
  } fsc_class_t;

  // Slave controller register numbers on the link.
  localparam logic [15:0] REG_STATION = 16'h0000;
  localparam logic [15:0] REG_MBX_CFG = 16'h0001;
  localparam logic [15:0] REG_DC_CFG = 16'h0002;
  localparam logic [15:0] REG_SM_CFG = 16'h0003;
  localparam logic [15:0] REG_MEMORY_MAPPING_UNIT_CFG = 16'h0004;
  localparam logic [15:0] REG_STATE = 16'h0005;
  localparam int REG_CFG_N = 5;

  // Object dictionary indices and subindices.
  localparam logic [15:0] IDX_CTRL_MODE = 16'h2002;
  localparam logic [7:0] SUB_CTRL_MODE = 8'h01;
  localparam logic [15:0] IDX_SAVE = 16'h200E;
  localparam logic [7:0] SUB_SAVE_SEL = 8'h02;
  localparam logic [7:0] SUB_ALIAS = 8'h10;
  localparam logic [15:0] IDX_MODES = 16'h6502;
  localparam logic [15:0] MODES_MASK = 16'h03AD;
  localparam logic [15:0] IDX_RX_LO = 16'h1600;
  localparam logic [15:0] IDX_RX_HI = 16'h17FF;
  localparam logic [15:0] IDX_TX_LO = 16'h1A00;
  localparam logic [15:0] IDX_TX_HI = 16'h1BFF;
  localparam logic [15:0] IDX_RX_VAR = 16'h1600;
  localparam logic [15:0] IDX_RX_FIX_LO = 16'h1701;
  localparam logic [15:0] IDX_RX_FIX_HI = 16'h1705;
  localparam logic [15:0] IDX_TX_VAR = 16'h1A00;
  localparam logic [15:0] IDX_TX_FIX_LO = 16'h1B01;
  localparam logic [15:0] IDX_TX_FIX_HI = 16'h1B04;
  localparam logic [15:0] IDX_COMM_LO = 16'h1000;
  localparam logic [15:0] IDX_MANUF_LO = 16'h2000;
  localparam logic [15:0] IDX_PROF_LO = 16'h6000;
  localparam logic [15:0] IDX_PROF_HI = 16'h9FFF;
  localparam logic [15:0] VAR_MAP_MAX = 16'h000A;
  localparam logic [15:0] MAP_KIND_FIXED = 16'h0001;

  // Control mode codes and defaults.
  localparam logic [15:0] MODE_SPEED = 16'h0000;
  localparam logic [15:0] MODE_POS = 16'h0001;
  localparam logic [15:0] MODE_TORQUE = 16'h0002;
  localparam logic [15:0] MODE_BUS = 16'h0009;
  localparam logic [15:0] MODE_UNUSED = 16'h00FF;
  localparam logic [15:0] SAVE_MAX = 16'h0003;
  localparam logic [15:0] SAVE_DEF = 16'h0003;
  localparam logic [15:0] ALIAS_DEF = 16'h0000;
  localparam int SAVE_PARAM_BIT = 0;
  localparam int SAVE_OD_BIT = 1;

  // Controller register byte offsets on APB.
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_ADDR = 8'h04;
  localparam logic [7:0] APB_WDATA = 8'h08;
  localparam logic [7:0] APB_RDATA = 8'h0C;
  localparam logic [7:0] APB_STATUS = 8'h10;
  localparam logic [7:0] APB_CYC = 8'h14;
  localparam logic [7:0] APB_RPDO = 8'h18;
  localparam logic [7:0] APB_TPDO = 8'h1C;

endpackage

// file: rtl/fsc_slave.sv
// Slave end: communication state machine, object access and PDO gating.
`timescale 1ns/1ps
module fsc_slave (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  fsc_link_if.dev lnk, // Link to the master.
  input wire logic [31:0] tx_data, // Drive values to send.
  output logic [31:0] rx_data, // Applied received values.
  output logic rx_valid, // Pulse when rx_data is updated.
  output logic [15:0] ctrl_mode, // Active control mode.
  output logic [15:0] save_sel, // Active save selection.
  output logic [15:0] alias_val, // Active station alias.
  output logic clock_sync_en, // Distributed clock usable.
  input wire logic save_strobe, // Store to non-volatile copy.
  input wire logic power_on_load // Reload from non-volatile copy.
);
  import fsc_pkg::*;

  fsc_state_t state_q; // Current state.
  logic ack_q; // Answer strobe.
  logic err_q; // Answer refused.
  logic [15:0] rdata_q; // Answer data.
  logic [15:0] cfg_q [REG_CFG_N]; // Controller registers.
  logic [REG_CFG_N-1:0] cfg_set_q; // Register written since reset.
  logic rpdo_seen_q; // Valid outputs seen in safe-op or op.
  logic [15:0] mode_q; // Control mode.
  logic [15:0] save_q; // Save selection.
  logic [15:0] alias_q; // Station alias.
  logic [15:0] rx_cnt_q; // Variable receive mapping entries.
  logic [15:0] tx_cnt_q; // Variable transmit mapping entries.
  logic [15:0] nv_mode_q; // Stored control mode.
  logic [15:0] nv_alias_q; // Stored alias.
  logic [15:0] nv_rx_q; // Stored receive mapping entries.
  logic [15:0] nv_tx_q; // Stored transmit mapping entries.
  logic [31:0] rx_q; // Applied received data.
  logic rx_v_q; // Received data strobe.
  logic tpdo_v_q; // Transmit data valid.
  logic [31:0] tpdo_q; // Transmit data.
  logic take; // Request accepted this cycle.
  logic ok; // Request is legal.
  logic [15:0] rd; // Read value of the request.
  fsc_state_t tgt; // Requested state.
  fsc_class_t cls; // Class of the requested index.
  logic mbx_on; // Mailbox open in this state.

  // Class of an object index.
  function automatic fsc_class_t obj_class(input logic [15:0] idx);
    if (idx >= IDX_PROF_LO && idx <= IDX_PROF_HI) begin
      return FSC_CL_PROF;
    end else if (idx >= IDX_MANUF_LO && idx < IDX_PROF_LO) begin
      return FSC_CL_MANUF;
    end else if (idx >= IDX_COMM_LO && idx < IDX_MANUF_LO) begin
      return FSC_CL_COMM;
    end
    return FSC_CL_RSVD;
  endfunction

  assign take = lnk.valid && !ack_q;
  assign tgt = fsc_state_t'(lnk.wdata[1:0]);
  assign cls = obj_class(lnk.index);
  assign mbx_on = state_q != FSC_ST_INIT;

  assign lnk.ack = ack_q;
  assign lnk.err = err_q;
  assign lnk.rdata = rdata_q;
  assign lnk.state = state_q;
  assign lnk.tpdo_valid = tpdo_v_q;
  assign lnk.tpdo_data = tpdo_q;
  assign rx_data = rx_q;
  assign rx_valid = rx_v_q;
  assign ctrl_mode = mode_q;
  assign save_sel = save_q;
  assign alias_val = alias_q;
  assign clock_sync_en = state_q >= FSC_ST_SAFEOP;

  // Decodes legality and read value of the pending request.
  always_comb begin
    ok = 1'b0;
    rd = 16'h0000;
    case (lnk.op)
      FSC_OP_REG_WR: begin
        ok = lnk.index < REG_STATE;
      end
      FSC_OP_REG_RD: begin
        ok = lnk.index <= REG_STATE;
        if (lnk.index == REG_STATE) begin
          rd = {14'h0000, state_q};
        end else if (lnk.index < REG_STATE) begin
          rd = cfg_q[lnk.index[2:0]];
        end
      end
      FSC_OP_MBX_WR: begin
        if (!mbx_on) begin
          ok = 1'b0;
        end else if (cls == FSC_CL_MANUF && lnk.index == IDX_CTRL_MODE &&
                     lnk.sub == SUB_CTRL_MODE) begin
          ok = lnk.wdata == MODE_SPEED || lnk.wdata == MODE_POS ||
               lnk.wdata == MODE_TORQUE || lnk.wdata == MODE_BUS ||
               lnk.wdata == MODE_UNUSED;
        end else if (cls == FSC_CL_MANUF && lnk.index == IDX_SAVE) begin
          ok = (lnk.sub == SUB_SAVE_SEL && lnk.wdata <= SAVE_MAX) ||
               lnk.sub == SUB_ALIAS;
        end else if (lnk.index == IDX_RX_VAR || lnk.index == IDX_TX_VAR) begin
          // Variable mappings change only in pre-op, before PDO runs.
          ok = state_q == FSC_ST_PREOP && lnk.sub == 8'h00 &&
               lnk.wdata <= VAR_MAP_MAX;
        end
      end
      FSC_OP_MBX_RD: begin
        if (!mbx_on) begin
          ok = 1'b0;
        end else if (lnk.index == IDX_CTRL_MODE &&
                     lnk.sub == SUB_CTRL_MODE) begin
          ok = 1'b1;
          rd = mode_q;
        end else if (lnk.index == IDX_SAVE && lnk.sub == SUB_SAVE_SEL) begin
          ok = 1'b1;
          rd = save_q;
        end else if (lnk.index == IDX_SAVE && lnk.sub == SUB_ALIAS) begin
          ok = 1'b1;
          rd = alias_q;
        end else if (cls == FSC_CL_PROF && lnk.index == IDX_MODES) begin
          ok = 1'b1;
          rd = MODES_MASK;
        end else if (lnk.index >= IDX_RX_LO && lnk.index <= IDX_RX_HI) begin
          // Receive mapping range: one variable, five fixed.
          ok = lnk.index == IDX_RX_VAR ||
               (lnk.index >= IDX_RX_FIX_LO && lnk.index <= IDX_RX_FIX_HI);
          rd = lnk.index == IDX_RX_VAR ? rx_cnt_q : MAP_KIND_FIXED;
        end else if (lnk.index >= IDX_TX_LO && lnk.index <= IDX_TX_HI) begin
          // Transmit mapping range: one variable, four fixed.
          ok = lnk.index == IDX_TX_VAR ||
               (lnk.index >= IDX_TX_FIX_LO && lnk.index <= IDX_TX_FIX_HI);
          rd = lnk.index == IDX_TX_VAR ? tx_cnt_q : MAP_KIND_FIXED;
        end
      end
      FSC_OP_STATE_REQ: begin
        if (tgt <= state_q) begin
          ok = 1'b1;
        end else if (tgt == FSC_ST_PREOP && state_q == FSC_ST_INIT) begin
          ok = &cfg_set_q[2:0];
        end else if (tgt == FSC_ST_SAFEOP && state_q == FSC_ST_PREOP) begin
          ok = &cfg_set_q[4:3];
        end else if (tgt == FSC_ST_OP && state_q == FSC_ST_SAFEOP) begin
          ok = rpdo_seen_q;
        end
      end
      default: begin
        ok = 1'b0;
      end
    endcase
  end

  // Answer strobe, one cycle per request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= take;
      if (take) begin
        err_q <= !ok;
        rdata_q <= ok ? rd : 16'h0000;
      end
    end
  end

  // Communication state machine, reset into init.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FSC_ST_INIT;
    end else if (take && ok && lnk.op == FSC_OP_STATE_REQ) begin
      case (tgt)
        FSC_ST_INIT: state_q <= FSC_ST_INIT;
        FSC_ST_PREOP: state_q <= FSC_ST_PREOP;
        FSC_ST_SAFEOP: state_q <= FSC_ST_SAFEOP;
        FSC_ST_OP: state_q <= FSC_ST_OP;
        default: state_q <= FSC_ST_INIT;
      endcase
    end
  end

  // Controller registers, writable in every state.
  for (genvar i = 0; i < REG_CFG_N; i++) begin : g_cfg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_q[i] <= 16'h0000;
        cfg_set_q[i] <= 1'b0;
      end else if (take && ok && lnk.op == FSC_OP_REG_WR &&
                   lnk.index[2:0] == 3'(i)) begin
        cfg_q[i] <= lnk.wdata;
        cfg_set_q[i] <= 1'b1;
      end
    end
  end

  // Valid outputs must be seen in safe-op before going operational.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpdo_seen_q <= 1'b0;
    end else if (state_q < FSC_ST_SAFEOP) begin
      rpdo_seen_q <= 1'b0;
    end else if (lnk.rpdo_valid) begin
      rpdo_seen_q <= 1'b1;
    end
  end

  // Working parameters; a power-on reload overrides a mailbox write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_BUS;
      save_q <= SAVE_DEF;
      alias_q <= ALIAS_DEF;
      rx_cnt_q <= 16'h0000;
      tx_cnt_q <= 16'h0000;
    end else if (power_on_load) begin
      mode_q <= nv_mode_q;
      alias_q <= nv_alias_q;
      rx_cnt_q <= nv_rx_q;
      tx_cnt_q <= nv_tx_q;
    end else if (take && ok && lnk.op == FSC_OP_MBX_WR) begin
      // Acyclic access to parameter and mapping objects.
      if (lnk.index == IDX_CTRL_MODE) begin
        mode_q <= lnk.wdata;
      end else if (lnk.index == IDX_SAVE && lnk.sub == SUB_SAVE_SEL) begin
        save_q <= lnk.wdata;
      end else if (lnk.index == IDX_SAVE) begin
        alias_q <= lnk.wdata;
      end else if (lnk.index == IDX_RX_VAR) begin
        rx_cnt_q <= lnk.wdata;
      end else begin
        tx_cnt_q <= lnk.wdata;
      end
    end
  end

  // Non-volatile copy; what is not saved keeps its last stored value, the default after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_mode_q <= MODE_BUS;
      nv_alias_q <= ALIAS_DEF;
      nv_rx_q <= 16'h0000;
      nv_tx_q <= 16'h0000;
    end else if (save_strobe) begin
      if (save_q[SAVE_PARAM_BIT]) begin
        nv_mode_q <= mode_q;
        nv_alias_q <= alias_q;
      end
      if (save_q[SAVE_OD_BIT]) begin
        nv_rx_q <= rx_cnt_q;
        nv_tx_q <= tx_cnt_q;
      end
    end
  end

  // Received outputs are applied only when operational.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 32'h0000_0000;
      rx_v_q <= 1'b0;
    end else begin
      rx_v_q <= lnk.rpdo_valid && state_q == FSC_ST_OP;
      if (lnk.rpdo_valid && state_q == FSC_ST_OP) begin
        rx_q <= lnk.rpdo_data;
      end
    end
  end

  // Inputs are sent every cycle in safe-op and operational.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tpdo_v_q <= 1'b0;
      tpdo_q <= 32'h0000_0000;
    end else begin
      tpdo_v_q <= state_q >= FSC_ST_SAFEOP;
      tpdo_q <= state_q >= FSC_ST_SAFEOP ? tx_data : 32'h0000_0000;
    end
  end
endmodule

// file: tb/fsc_link_assertions.sv
// Concurrent checks on the link between the master and slave ends.
`timescale 1ns/1ps
module fsc_link_assertions (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire fsc_pkg::fsc_op_t op, // Request kind.
  input wire logic valid, // Request held.
  input wire logic [15:0] wdata, // Write data or target state.
  input wire logic ack, // Answer strobe.
  input wire logic err, // Refusal flag.
  input wire logic [15:0] rdata, // Read data.
  input wire fsc_pkg::fsc_state_t state, // Slave state.
  input wire logic tpdo_valid // Input data valid.
);
  import fsc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic take; // The slave takes a request.
  logic sreq; // A state request is taken.
  assign take = valid && !ack;
  assign sreq = take && op == FSC_OP_STATE_REQ;
  // The answer is a single pulse in the cycle after the take.
  sequence s_pulse;
    ack ##1 !ack;
  endsequence
  // A refusal leaves the state where it was.
  sequence s_refuse;
    err && $stable(state);
  endsequence
  link_handshake_a:
  assert property (take |=> s_pulse)
    else $error("link answer is not a single pulse");
  answer_hold_a:
  assert property (!ack |-> $stable(err) && $stable(rdata))
    else $error("answer fields moved without an answer");
  err_rdata_a:
  assert property (ack && err |-> rdata == 16'h0000)
    else $error("refused answer carries data");
  init_mbx_a:
  assert property (take && state == FSC_ST_INIT &&
    (op == FSC_OP_MBX_WR || op == FSC_OP_MBX_RD) |=> err)
    else $error("mailbox accepted in init");
  up_one_a:
  assert property (state > $past(state) |-> state == $past(state) + 1)
    else $error("upward move skipped a state");
  skip_refuse_a:
  assert property (sreq && wdata > 16'(state) + 16'h0001 |=> s_refuse)
    else $error("skipping request not refused");
  down_accept_a:
  assert property (sreq && wdata < 16'(state) |=>
    !err && 16'(state) == $past(wdata))
    else $error("downward request not taken");
  state_by_req_a:
  assert property (state != $past(state) |-> ack && $past(sreq))
    else $error("state moved without a state request");
  tpdo_gate_a:
  assert property (tpdo_valid == ($past(state) >= FSC_ST_SAFEOP))
    else $error("input data valid in wrong state");
endmodule

// file: tb/tb_fieldbus_slave_state_control.sv
// Bench joining the master and slave ends over the link.
`timescale 1ns/1ps
module tb_fieldbus_slave_state_control;
  import fsc_pkg::*;
  localparam fsc_op_t WR = FSC_OP_MBX_WR;
  localparam fsc_op_t RD = FSC_OP_MBX_RD;
  localparam fsc_op_t SQ = FSC_OP_STATE_REQ;
  logic pclk = 1'b0; // Bench clock.
  logic presetn = 1'b0; // Reset, held at start.
  logic psel = 1'b0; // APB select.
  logic penable = 1'b0; // APB enable.
  logic pwrite = 1'b0; // APB direction.
  logic [7:0] paddr = 8'h00; // APB address.
  logic [31:0] pwdata = 32'h0000_0000; // APB write data.
  logic [31:0] tx_data = 32'hCAFE_0001; // Drive values sent back.
  logic save_strobe = 1'b0; // Store request.
  logic power_on_load = 1'b0; // Reload request.
  logic [31:0] prdata, rx_data, q; // Read data and last APB result.
  logic [15:0] ctrl_mode, save_sel, alias_val; // Slave settings.
  logic pready, pslverr, pe, rx_valid, clock_sync_en; // Status pins.
  int n_mismatch = 0; // Mismatches seen.
  int total_checks = 0; // Comparisons made.
  int cyc = 0; // Cycles run.
  int rx_cnt = 0; // Applied receive words.
  fsc_link_if link();
  fsc_master u_fsc_master(.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .lnk(link));
  fsc_slave u_fsc_slave(.pclk, .presetn, .lnk(link), .tx_data, .rx_data,
    .rx_valid, .ctrl_mode, .save_sel, .alias_val, .clock_sync_en,
    .save_strobe, .power_on_load);
  fsc_link_assertions u_fsc_link_assertions(.pclk, .presetn, .op(link.op),
    .valid(link.valid), .wdata(link.wdata), .ack(link.ack),
    .err(link.err), .rdata(link.rdata), .state(link.state),
    .tpdo_valid(link.tpdo_valid));
  // Free-running clock.
  initial begin
    forever #10 pclk = ~pclk;
  end
  // Count applied words and cut a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Compares one value with its expectation.
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; read data lands in q, the error flag in pe.
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sends one link request and checks the answer.
  task automatic ex(fsc_op_t o, logic [15:0] i, logic [7:0] s,
      logic [15:0] w, logic ee, logic [15:0] er);
    apb(1'b1, APB_ADDR, {8'h00, s, i});
    apb(1'b1, APB_WDATA, {16'h0000, w});
    apb(1'b1, APB_CMD, {29'h0000_0000, o});
    do apb(1'b0, APB_STATUS, 32'h0000_0000); while (q[0] !== 1'b0);
    chk("link err", {31'h0000_0000, q[1]}, {31'h0000_0000, ee});
    apb(1'b0, APB_RDATA, 32'h0000_0000);
    if (o == RD || o == FSC_OP_REG_RD || ee)
      chk("link rdata", q, {16'h0000, er});
  endtask
  // Reads the slave state through the status register.
  task automatic st(fsc_state_t s);
    apb(1'b0, APB_STATUS, 32'h0000_0000);
    chk("state", {30'h0000_0000, q[5:4]}, {30'h0000_0000, s});
  endtask
  // Pulses the store and reload pins for one cycle.
  task automatic nv(logic s, logic l);
    @(posedge pclk);
    save_strobe <= s;
    power_on_load <= l;
    @(posedge pclk);
    save_strobe <= 1'b0;
    power_on_load <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_init();
    chk("mode", ctrl_mode, MODE_BUS);
    chk("save", save_sel, SAVE_DEF);
    st(FSC_ST_INIT);
    ex(FSC_OP_REG_RD, REG_STATE, 8'h00, 16'h0000, 1'b0, 16'h0000);
    ex(RD, IDX_CTRL_MODE, SUB_CTRL_MODE, 16'h0000, 1'b1, 16'h0000);
    ex(SQ, 16'h0000, 8'h00, 16'h0001, 1'b1, 16'h0000);
    for (int k = 0; k < 3; k++)
      ex(FSC_OP_REG_WR, 16'(k), 8'h00, 16'h0001, 1'b0, 16'h0000);
    ex(FSC_OP_REG_WR, REG_STATE, 8'h00, 16'h0001, 1'b1, 16'h0000);
    ex(SQ, 16'h0000, 8'h00, 16'h0002, 1'b1, 16'h0000);
    ex(SQ, 16'h0000, 8'h00, 16'h0001, 1'b0, 16'h0000);
    st(FSC_ST_PREOP);
    $display("test init done");
  endtask
  task automatic t_preop();
    logic [15:0] m[5] = '{MODE_SPEED, MODE_POS, MODE_TORQUE, MODE_UNUSED,
      MODE_BUS};
    foreach (m[k]) begin
      ex(WR, IDX_CTRL_MODE, SUB_CTRL_MODE, m[k], 1'b0, 16'h0000);
      chk("mode", ctrl_mode, m[k]);
    end
    ex(WR, IDX_CTRL_MODE, SUB_CTRL_MODE, 16'h0003, 1'b1, 16'h0000);
    ex(WR, IDX_SAVE, SUB_SAVE_SEL, 16'h0004, 1'b1, 16'h0000);
    ex(RD, IDX_MODES, 8'h00, 16'h0000, 1'b0, MODES_MASK);
    ex(WR, IDX_RX_VAR, 8'h00, 16'h000B, 1'b1, 16'h0000);
    ex(WR, IDX_RX_VAR, 8'h00, VAR_MAP_MAX, 1'b0, 16'h0000);
    ex(RD, IDX_RX_VAR, 8'h00, 16'h0000, 1'b0, VAR_MAP_MAX);
    nv(1'b1, 1'b0);
    ex(RD, IDX_RX_FIX_HI, 8'h00, 16'h0000, 1'b0, MAP_KIND_FIXED);
    ex(RD, IDX_TX_FIX_HI, 8'h00, 16'h0000, 1'b0, MAP_KIND_FIXED);
    ex(RD, IDX_TX_HI, 8'h00, 16'h0000, 1'b1, 16'h0000);
    ex(SQ, 16'h0000, 8'h00, 16'h0003, 1'b1, 16'h0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", {pe, q[30:0]}, 32'h8000_0000);
    apb(1'b1, APB_RPDO, 32'h1234_5678);
    apb(1'b1, APB_CYC, 32'h0000_0001);
    chk("rx in preop", rx_cnt, 32'h0000_0000);
    chk("clock", clock_sync_en, 32'h0000_0000);
    $display("test preop done");
  endtask
  task automatic t_run();
    ex(FSC_OP_REG_WR, REG_SM_CFG, 8'h00, 16'h0001, 1'b0, 16'h0000);
    ex(FSC_OP_REG_WR, REG_MEMORY_MAPPING_UNIT_CFG, 8'h00, 16'h0001, 1'b0, 16'h0000);
    ex(SQ, 16'h0000, 8'h00, 16'h0002, 1'b0, 16'h0000);
    chk("clock", clock_sync_en, 32'h0000_0001);
    apb(1'b0, APB_TPDO, 32'h0000_0000);
    chk("tpdo", q, tx_data);
    chk("rx in safeop", rx_cnt, 32'h0000_0000);
    ex(SQ, 16'h0000, 8'h00, 16'h0003, 1'b0, 16'h0000);
    st(FSC_ST_OP);
    chk("rx data", rx_data, 32'h1234_5678);
    chk("rx seen", 32'(rx_cnt > 0), 32'h0000_0001);
    ex(RD, IDX_MODES, 8'h00, 16'h0000, 1'b0, MODES_MASK);
    $display("test run done");
  endtask
  task automatic t_save();
    ex(WR, IDX_SAVE, SUB_SAVE_SEL, 16'h0000, 1'b0, 16'h0000);
    ex(WR, IDX_CTRL_MODE, SUB_CTRL_MODE, MODE_POS, 1'b0, 16'h0000);
    nv(1'b1, 1'b0);
    nv(1'b0, 1'b1);
    chk("unsaved mode", ctrl_mode, MODE_BUS);
    ex(RD, IDX_RX_VAR, 8'h00, 16'h0000, 1'b0, VAR_MAP_MAX);
    ex(WR, IDX_SAVE, SUB_SAVE_SEL, 16'h0001, 1'b0, 16'h0000);
    ex(WR, IDX_SAVE, SUB_ALIAS, 16'h0005, 1'b0, 16'h0000);
    ex(WR, IDX_CTRL_MODE, SUB_CTRL_MODE, MODE_TORQUE, 1'b0, 16'h0000);
    nv(1'b1, 1'b0);
    ex(WR, IDX_CTRL_MODE, SUB_CTRL_MODE, MODE_SPEED, 1'b0, 16'h0000);
    nv(1'b0, 1'b1);
    chk("saved mode", ctrl_mode, MODE_TORQUE);
    chk("save sel", save_sel, 32'h0000_0001);
    chk("alias", alias_val, 32'h0000_0005);
    $display("test save done");
  endtask
  task automatic t_down();
    ex(SQ, 16'h0000, 8'h00, 16'h0000, 1'b0, 16'h0000);
    st(FSC_ST_INIT);
    chk("clock", clock_sync_en, 32'h0000_0000);
    chk("tpdo off", link.tpdo_valid, 32'h0000_0000);
    ex(WR, IDX_SAVE, SUB_ALIAS, 16'h0005, 1'b1, 16'h0000);
    $display("test down done");
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_init();
    t_preop();
    t_run();
    t_save();
    t_down();
    final_report();
  end
endmodule
